// ---- src/serial_command_port_pkg.sv ----
// constants for the serial command port: baud timing, frame and command lengths
// assumes a 40 MHz system clock and a host on an rs-232 line
// What this block does
// - strap high or open at reset selects 56700 baud
// - strap low at reset selects 115200 baud
// - frames are 8 data bits, no parity, one stop bit, no flow control
// - after the address byte, collect exactly that register's data bytes
// - no timeout: an incomplete command waits forever
// - after execution send one acknowledge byte with bit 1 set; if query reply bytes are still queued the next reply byte takes the line and the acknowledge is lost
// - query registers 0x20 to 0x26 each return six bytes of response data
// - a command is 2 to 6 bytes, address first then data
package serial_command_port_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned BAUD_SLOW = 56700;
  localparam int unsigned BAUD_FAST = 115200;
  localparam int unsigned OVERSAMPLE = 16;
  // oversample tick divider, rounded to nearest
  localparam logic [7:0] TICK_DIV_SLOW =
    8'((CLK_HZ + BAUD_SLOW * OVERSAMPLE / 2) / (BAUD_SLOW * OVERSAMPLE));
  localparam logic [7:0] TICK_DIV_FAST =
    8'((CLK_HZ + BAUD_FAST * OVERSAMPLE / 2) / (BAUD_FAST * OVERSAMPLE));
  localparam logic [3:0] TICK_LAST = 4'hf;
  localparam logic [3:0] TICK_MID = 4'h7;
  // clocks after reset release before the strap synchroniser shows the pin
  localparam logic [1:0] STRAP_WAIT = 2'h2;
  localparam logic [2:0] DATA_BITS_LAST = 3'h7;
  localparam logic [2:0] CMD_DATA_MIN = 3'h1;
  localparam logic [2:0] CMD_DATA_MAX = 3'h5;
  localparam logic [7:0] ACK_BYTE = 8'h02;
  localparam logic [7:0] QUERY_BASE = 8'h20;
  localparam logic [7:0] QUERY_LAST = 8'h26;
  localparam logic [2:0] QUERY_REPLY_LEN = 3'h6;
endpackage

// ---- src/uart_tick_gen.sv ----
// oversample tick generator, one pulse every div_in clocks
// assumes div_in is stable after reset
`timescale 1ns/1ps
`default_nettype none
module uart_tick_gen
  import serial_command_port_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic [7:0] div_in,
  output logic tick_out
);
  logic [7:0] count;
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      count <= 8'h00;
    end else if (count >= div_in - 8'h01) begin
      count <= 8'h00;
    end else begin
      count <= count + 8'h01;
    end
  end
  assign tick_out = (count == 8'h00);
endmodule
`default_nettype wire

// ---- src/serial_command_port.sv ----
// serial command port: uart receive, command assembly, acknowledge and query reply
// assumes the register engine executes in one cycle after cmd_valid_out
`timescale 1ns/1ps
`default_nettype none
module serial_command_port
  import serial_command_port_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_n_in,
  input wire logic baud_strap_in,
  input wire logic rxd_in,
  output logic txd_out,
  output logic [7:0] cmd_addr_out,
  output logic [39:0] cmd_data_out,
  output logic cmd_valid_out,
  input wire logic [47:0] query_data_in,
  output logic baud_fast_out,
  output logic busy_out
);
  typedef enum {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
  typedef enum {CMD_ADDR, CMD_DATA, CMD_EXEC} cmd_state_t;
  typedef enum {TX_IDLE, TX_START, TX_DATA, TX_STOP} tx_state_t;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!reset_n_in);
  logic rxd_meta, rxd_sync, strap_meta, strap_sync, strap_taken;
  logic tick;
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rxd_meta <= 1'b1;
      rxd_sync <= 1'b1;
      strap_meta <= 1'b1;
      strap_sync <= 1'b1;
    end else begin
      rxd_meta <= rxd_in;
      rxd_sync <= rxd_meta;
      strap_meta <= baud_strap_in;
      strap_sync <= strap_meta;
    end
  end
  // strap caught once after release; later changes need a reset
  logic [1:0] strap_wait;
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      strap_wait <= 2'h0;
      strap_taken <= 1'b0;
      baud_fast_out <= 1'b0;
    end else if (strap_wait != STRAP_WAIT) begin
      // sync flops still hold their reset value, not the pin
      strap_wait <= strap_wait + 2'h1;
    end else if (!strap_taken) begin
      strap_taken <= 1'b1;
      baud_fast_out <= !strap_sync;
    end
  end
  uart_tick_gen u_tick (
    .clk_sys_in(clk_sys_in),
    .reset_n_in(reset_n_in),
    .div_in(baud_fast_out ? TICK_DIV_FAST : TICK_DIV_SLOW),
    .tick_out(tick)
  );
  // receiver
  rx_state_t rx_state;
  logic [3:0] rx_tick;
  logic [2:0] rx_bit;
  logic [7:0] rx_shift;
  logic rx_done;
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rx_state <= RX_IDLE;
      rx_tick <= 4'h0;
      rx_bit <= 3'h0;
      rx_shift <= 8'h00;
      rx_done <= 1'b0;
    end else begin
      rx_done <= 1'b0;
      case (rx_state)
        RX_IDLE: begin
          rx_tick <= 4'h0;
          if (strap_taken && !rxd_sync) begin
            rx_state <= RX_START;
          end
        end
        RX_START: begin
          if (tick) begin
            if (rx_tick == TICK_MID) begin
              rx_tick <= 4'h0;
              rx_bit <= 3'h0;
              // glitch shorter than half a bit is dropped
              rx_state <= rxd_sync ? RX_IDLE : RX_DATA;
            end else begin
              rx_tick <= rx_tick + 4'h1;
            end
          end
        end
        RX_DATA: begin
          if (tick) begin
            rx_tick <= rx_tick + 4'h1;
            if (rx_tick == TICK_LAST) begin
              rx_shift <= {rxd_sync, rx_shift[7:1]};
              rx_bit <= rx_bit + 3'h1;
              if (rx_bit == DATA_BITS_LAST) begin
                rx_state <= RX_STOP;
              end
            end
          end
        end
        RX_STOP: begin
          if (tick) begin
            rx_tick <= rx_tick + 4'h1;
            if (rx_tick == TICK_LAST) begin
              rx_state <= RX_IDLE;
              rx_done <= rxd_sync; // framing error drops the byte
            end
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end
  // data bytes expected per address; unknown addresses take one
  function automatic logic [2:0] data_len(input logic [7:0] addr);
    logic [2:0] len;
    len = CMD_DATA_MIN;
    if (addr == 8'h06 || addr == 8'h07) begin
      len = CMD_DATA_MAX;
    end else if (addr == 8'h08) begin
      len = 3'h4;
    end else if (addr == 8'h09 || addr == 8'h0a || addr == 8'h0c) begin
      len = 3'h3;
    end
    return len;
  endfunction
  // command assembly; no timeout by design
  cmd_state_t cmd_state;
  logic [2:0] cmd_need, cmd_got;
  logic tx_busy, ack_req;
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cmd_state <= CMD_ADDR;
      cmd_need <= 3'h0;
      cmd_got <= 3'h0;
      cmd_addr_out <= 8'h00;
      cmd_data_out <= 40'h0;
      cmd_valid_out <= 1'b0;
      ack_req <= 1'b0;
    end else begin
      cmd_valid_out <= 1'b0;
      ack_req <= 1'b0;
      case (cmd_state)
        CMD_ADDR: begin
          if (rx_done) begin
            cmd_addr_out <= rx_shift;
            cmd_data_out <= 40'h0;
            cmd_need <= data_len(rx_shift);
            cmd_got <= 3'h0;
            cmd_state <= CMD_DATA;
          end
        end
        CMD_DATA: begin
          // waits forever for missing bytes
          if (rx_done) begin
            cmd_data_out <= {cmd_data_out[31:0], rx_shift};
            cmd_got <= cmd_got + 3'h1;
            if (cmd_got + 3'h1 == cmd_need) begin
              cmd_state <= CMD_EXEC;
            end
          end
        end
        CMD_EXEC: begin
          if (!tx_busy) begin
            cmd_valid_out <= 1'b1;
            ack_req <= 1'b1;
            cmd_state <= CMD_ADDR;
          end
        end
        default: cmd_state <= CMD_ADDR;
      endcase
    end
  end
  // transmitter: ack byte, then reply bytes for query addresses
  tx_state_t tx_state;
  logic [3:0] tx_tick;
  logic [2:0] tx_bit, tx_left;
  logic [7:0] tx_shift;
  logic [47:0] reply;
  logic is_query;
  assign is_query = (cmd_addr_out >= QUERY_BASE) && (cmd_addr_out <= QUERY_LAST);
  assign tx_busy = (tx_state != TX_IDLE);
  always_ff @(posedge clk_sys_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      tx_state <= TX_IDLE;
      tx_tick <= 4'h0;
      tx_bit <= 3'h0;
      tx_left <= 3'h0;
      tx_shift <= 8'hff;
      reply <= 48'h0;
      txd_out <= 1'b1;
    end else begin
      case (tx_state)
        TX_IDLE: begin
          txd_out <= 1'b1;
          if (ack_req) begin
            tx_shift <= ACK_BYTE;
            reply <= query_data_in;
            tx_left <= is_query ? QUERY_REPLY_LEN : 3'h0;
            tx_tick <= 4'h0;
            tx_state <= TX_START;
          end else if (tx_left != 3'h0) begin
            tx_shift <= reply[47:40];
            reply <= {reply[39:0], 8'h00};
            tx_left <= tx_left - 3'h1;
            tx_tick <= 4'h0;
            tx_state <= TX_START;
          end
        end
        TX_START: begin
          txd_out <= 1'b0;
          if (tick) begin
            tx_tick <= tx_tick + 4'h1;
            if (tx_tick == TICK_LAST) begin
              tx_bit <= 3'h0;
              tx_state <= TX_DATA;
            end
          end
        end
        TX_DATA: begin
          txd_out <= tx_shift[0];
          if (tick) begin
            tx_tick <= tx_tick + 4'h1;
            if (tx_tick == TICK_LAST) begin
              tx_shift <= {1'b1, tx_shift[7:1]};
              tx_bit <= tx_bit + 3'h1;
              if (tx_bit == DATA_BITS_LAST) begin
                tx_state <= TX_STOP;
              end
            end
          end
        end
        TX_STOP: begin
          txd_out <= 1'b1;
          if (tick) begin
            tx_tick <= tx_tick + 4'h1;
            if (tx_tick == TICK_LAST) begin
              tx_state <= TX_IDLE;
            end
          end
        end
        default: tx_state <= TX_IDLE;
      endcase
    end
  end
  assign busy_out = (cmd_state != CMD_ADDR) || tx_busy || (tx_left != 3'h0);
  // the acknowledge follows an executed command only when no query reply bytes are queued; otherwise the next reply byte starts and the ack is lost
  property p_ack_after_exec;
    cmd_valid_out |=> (tx_state == TX_START) && (tx_shift == ACK_BYTE);
  endproperty
  a_ack_after_exec: assert property (p_ack_after_exec)
    else $error("no ack after command");
  property p_strap_fixed;
    strap_taken && $past(strap_taken) |-> $stable(baud_fast_out);
  endproperty
  a_strap_fixed: assert property (p_strap_fixed)
    else $error("baud changed without reset");
  property p_len_bound;
    cmd_state == CMD_DATA |-> cmd_got < cmd_need && cmd_need <= CMD_DATA_MAX;
  endproperty
  a_len_bound: assert property (p_len_bound)
    else $error("data count out of range");
  property p_start_bit;
    tx_state == TX_START |=> !txd_out;
  endproperty
  a_start_bit: assert property (p_start_bit)
    else $error("start bit not low");
  property p_exec_only_full;
    cmd_valid_out |-> $past(cmd_state) == CMD_EXEC;
  endproperty
  a_exec_only_full: assert property (p_exec_only_full)
    else $error("command executed early");
  property p_stop_high;
    $fell(rx_state == RX_STOP) && rx_state == RX_IDLE |-> rx_done == $past(rxd_sync);
  endproperty
  a_stop_high: assert property (p_stop_high)
    else $error("byte taken with bad stop");
  property p_query_reply;
    ack_req && is_query |=> tx_left == QUERY_REPLY_LEN;
  endproperty
  a_query_reply: assert property (p_query_reply)
    else $error("query reply not queued");
  property p_idle_high;
    tx_state == TX_IDLE && $past(tx_state) == TX_IDLE |-> txd_out;
  endproperty
  a_idle_high: assert property (p_idle_high)
    else $error("line not idle high");
  c_cmd: cover property (@(posedge clk_sys_in) cmd_valid_out);
  c_query: cover property (@(posedge clk_sys_in) ack_req && is_query);
  c_long: cover property (@(posedge clk_sys_in) cmd_valid_out && cmd_addr_out == 8'h06);
  c_fast: cover property (@(posedge clk_sys_in) strap_taken && baud_fast_out);
endmodule
`default_nettype wire

// ---- dv/host_uart_model.sv ----
// host end of the serial line: sends command bytes, receives ack and reply bytes
// assumes bit_clks_in holds one bit time in clk_sys_in cycles
`timescale 1ns/1ps
`default_nettype none
module host_uart_model (
  input wire logic clk_sys_in,
  input wire logic [15:0] bit_clks_in,
  input wire logic txd_in,
  output logic rxd_out
);
  initial rxd_out = 1'b1;
  // 8 data bits lsb first, no parity, one stop bit, no flow control
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_sys_in) rxd_out = f[i];
      repeat (bit_clks_in - 1) @(negedge clk_sys_in);
    end
  endtask
  // every data byte goes out, zero bytes as well
  task automatic send_cmd(input logic [7:0] a, input int n, input logic [39:0] d);
    send_byte(a);
    for (int i = n - 1; i >= 0; i--) send_byte(d[i*8 +: 8]);
  endtask
  // low pulse well under half a bit, must not start a byte
  task automatic glitch();
    @(negedge clk_sys_in) rxd_out = 1'b0;
    repeat (bit_clks_in / 4) @(negedge clk_sys_in);
    rxd_out = 1'b1;
  endtask
  // txd is watched all the time: the ack starts while our last stop bit is
  // still going out, so a reader called afterwards would miss its start edge
  logic [7:0] got_byte [0:15];
  logic got_ok [0:15];
  logic [7:0] mon_byte;
  logic mon_ok;
  int got_count = 0;
  int read_count = 0;
  initial begin
    forever begin
      @(negedge txd_in);
      repeat (bit_clks_in / 2) @(posedge clk_sys_in);
      mon_ok = (txd_in === 1'b0);
      for (int i = 0; i < 8; i++) begin
        repeat (bit_clks_in) @(posedge clk_sys_in);
        mon_byte[i] = txd_in;
      end
      repeat (bit_clks_in) @(posedge clk_sys_in);
      got_ok[got_count % 16] = mon_ok && (txd_in === 1'b1);
      got_byte[got_count % 16] = mon_byte;
      got_count++;
    end
  end
  // bounded wait for the watcher to finish the next byte
  task automatic recv_byte(output logic [7:0] b, output logic ok);
    int w;
    w = 0;
    while (got_count <= read_count && w < 16 * bit_clks_in) begin
      @(posedge clk_sys_in);
      w++;
    end
    b = 8'h00;
    ok = 1'b0;
    if (got_count > read_count) begin
      b = got_byte[read_count % 16];
      ok = got_ok[read_count % 16];
      read_count++;
    end
  endtask
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
// self-checking bench for the serial command port
// assumes the host model drives rxd and reads txd; query data held constant
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin err_count++; \
  $display("BAD %s expected %h seen %h", nm, ex, got); end end
module testbench;
  import serial_command_port_pkg::*;
  logic clk_sys_in, reset_n_in, baud_strap_in, rxd, txd_out, cmd_valid_out;
  logic baud_fast_out, busy_out;
  logic [7:0] cmd_addr_out, rb;
  logic [39:0] cmd_data_out;
  logic [47:0] query_data_in;
  logic [15:0] bit_clks;
  logic ok;
  int err_count, check_count, pulses;
  serial_command_port u_serial_command_port (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in),
    .baud_strap_in(baud_strap_in), .rxd_in(rxd), .txd_out(txd_out),
    .cmd_addr_out(cmd_addr_out), .cmd_data_out(cmd_data_out), .cmd_valid_out(cmd_valid_out),
    .query_data_in(query_data_in), .baud_fast_out(baud_fast_out), .busy_out(busy_out));
  host_uart_model u_host_uart_model (.clk_sys_in(clk_sys_in), .bit_clks_in(bit_clks),
    .txd_in(txd_out), .rxd_out(rxd));
  initial begin
    clk_sys_in = 1'b0;
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  always @(posedge clk_sys_in) begin
    if (cmd_valid_out === 1'b1) pulses++;
  end
  task automatic complete_run();
    if (err_count == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // strap is only looked at around reset release
  task automatic rst(input logic strap);
    @(negedge clk_sys_in);
    reset_n_in = 1'b0;
    baud_strap_in = strap;
    bit_clks = 16'(strap ? 16 * TICK_DIV_SLOW : 16 * TICK_DIV_FAST);
    repeat (4) @(negedge clk_sys_in);
    reset_n_in = 1'b1;
    repeat (6) @(negedge clk_sys_in);
    pulses = 0;
  endtask
  // whole command, then the ack is read before anything else is sent
  task automatic do_cmd(input logic [7:0] a, input int n, input logic [39:0] d);
    u_host_uart_model.send_cmd(a, n, d);
    u_host_uart_model.recv_byte(rb, ok);
    `CHK("ack framing", 1'b1, ok)
    `CHK("ack bit1", 1'b1, rb[1])
    `CHK("ack byte", ACK_BYTE, rb)
    `CHK("cmd addr", a, cmd_addr_out)
    `CHK("cmd data", d, cmd_data_out)
    `CHK("exec pulses", 1, pulses)
    pulses = 0;
  endtask
  initial begin
    err_count = 0;
    check_count = 0;
    pulses = 0;
    reset_n_in = 1'b0;
    baud_strap_in = 1'b1;
    bit_clks = 16'd704;
    query_data_in = 48'ha1b2c3d4e5f6;
    rst(1'b1);
    `CHK("baud fast", 1'b0, baud_fast_out)
    do_cmd(8'h03, 1, 40'h01);
    rst(1'b0);
    `CHK("baud fast", 1'b1, baud_fast_out)
    u_host_uart_model.glitch();
    // long enough for a wrongly taken byte to reach the command stage
    repeat (10 * bit_clks) @(negedge clk_sys_in);
    `CHK("glitch busy", 1'b0, busy_out)
    do_cmd(8'h06, 5, 40'h00a5003c00);
    do_cmd(8'h20, 1, 40'h00);
    for (int i = 0; i < 6; i++) begin
      u_host_uart_model.recv_byte(rb, ok);
      `CHK("reply framing", 1'b1, ok)
      `CHK("reply byte", query_data_in[47 - 8*i -: 8], rb)
    end
    // short command: address plus two of three data bytes
    u_host_uart_model.send_cmd(8'h09, 2, 40'h0);
    repeat (10 * bit_clks) @(negedge clk_sys_in);
    `CHK("no exec", 0, pulses)
    `CHK("still busy", 1'b1, busy_out)
    `CHK("no ack", 1'b1, txd_out)
    `CHK("no ack byte", u_host_uart_model.read_count, u_host_uart_model.got_count)
    complete_run();
  end
  // a clean run takes about 94000 clocks
  initial begin
    repeat (100000) @(posedge clk_sys_in);
    err_count++;
    complete_run();
  end
endmodule
`default_nettype wire
